/* verilog/pasr_consts.svh */
// constants for the oscillator phase register slice
`ifndef PASR_CONSTS_SVH
`define PASR_CONSTS_SVH
`define PASR_ACC_W        20
`define PASR_ADDR_W       8
`define PASR_OFS_ACC_LOW  8'h00
`define PASR_OFS_ACC_HIGH 8'h04
`define PASR_OFS_ACC_UP   8'h08
`define PASR_OFS_STP_LOW  8'h0C
`define PASR_OFS_STP_HIGH 8'h10
`define PASR_OFS_STP_UP   8'h14
`define PASR_OFS_CTRL     8'h18
`define PASR_CTRL_EN_BIT  0
`define PASR_CTRL_PND_BIT 1
`define PASR_RST_ACC      20'h00000
`define PASR_RST_STEP     20'h00001
`endif

/* verilog/pasr_pkg.sv */
// types for the oscillator phase register slice
`default_nettype none
package pasr_pkg;
	// one apb request as seen by the slave
	typedef struct packed {
		logic [7:0]  addr;
		logic        write;
		logic [31:0] wdata;
		logic        strb0;
	} pasr_req_type;
endpackage
`default_nettype wire

/* verilog/pasr_top.sv */
// apb register slice with phase accumulator and double-buffered step
`timescale 1ns/1ps
`default_nettype none
`include "pasr_consts.svh"
module pasr_top #(
	parameter int ACC_W = `PASR_ACC_W
) (
	input  wire logic                      i_mclk,
	input  wire logic                      i_nrst,
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [`PASR_ADDR_W-1:0]   i_paddr,
	input  wire logic [31:0]               i_pwdata,
	input  wire logic [3:0]                i_pstrb,
	input  wire logic                      i_synth_input_clock,
	output logic      [31:0]               o_prdata,
	output logic                           o_pready,
	output logic                           o_pslverr,
	output logic      [ACC_W-1:0]          o_phase_accum,
	output logic                           o_overflow,
	output logic                           o_synth_enable
);
	// upper register carries bits 16 and up in its low byte;
	// below 17 bits it would be empty, above 24 it would not fit a byte
	if (ACC_W < 17 || ACC_W > 24) begin : g_bad_width
		$error("pasr_top: ACC_W must lie in 17..24");
	end

	// register map, one byte-wide register per aligned word:
	//   0x00  accumulator bits 7:0
	//   0x04  accumulator bits 15:8
	//   0x08  accumulator top bits in 3:0, bits 7:4 read zero
	//   0x0C  step bits 7:0, a write here while running arms the shadow load
	//   0x10  step bits 15:8
	//   0x14  step top bits in 3:0, bits 7:4 read zero
	//   0x18  control: bit 0 enable, bit 1 shadow load pending
	// other words answer with pslverr, read zero and ignore writes
	// write data above a register's width is ignored
	// strobe lanes above lane 0 are ignored, lane 0 gates every write

	// bus timing:
	//   pready is always high, so every transfer takes two cycles
	//   read data is latched in the setup cycle, not the access cycle
	//   a write lands at the edge that ends the access cycle

	// input clock timing:
	//   pin edges reach the adder three mclk edges late
	//   each level of the pin must last two mclk periods or more
	//   the new sum and its overflow pulse appear together

	// shadow load:
	//   running, a low step write arms it and the next fall loads it
	//   stopped, any step write loads it one edge after the write
	//   stopping with a load armed performs it at once

	// reset:
	//   accumulator clears, step and shadow start at one
	//   enable and pending clear; release reaches logic two edges late

	// limits for software:
	//   byte reads of a running accumulator may tear between bytes
	//   accumulator writes while running give undefined sums

	localparam int UP_W = ACC_W - 16;

	logic                 rst_a_q;
	logic                 rst_n;
	logic                 ck_rise;
	logic                 ck_fall;
	logic [ACC_W-1:0]     accum_q;
	logic [ACC_W-1:0]     step_q;
	logic [ACC_W-1:0]     shadow_q;
	logic [ACC_W:0]       sum_w;
	logic                 enable_q;
	logic                 pending_q;
	logic                 step_wr_seen_q;
	logic                 overflow_q;
	logic [31:0]          prdata_q;
	logic [31:0]          rd_mux;
	logic                 mapped;
	logic                 wr_ok;
	logic                 shadow_load;
	logic                 wr_acc_low;
	logic                 wr_acc_high;
	logic                 wr_acc_up;
	logic                 wr_stp_low;
	logic                 wr_stp_high;
	logic                 wr_stp_up;
	logic                 wr_ctrl;
	logic                 accum_add;
	pasr_pkg::pasr_req_type req;

	// reset released through two flops so release is clean on i_mclk
	// assertion stays asynchronous so the flopped outputs go quiet at once
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_a_q <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n   <= rst_a_q;
		end
	end

	// oscillator input clock is a pin here, so it is synchronised first;
	// edges are taken after the second flop only, which costs latency
	// but keeps a metastable first stage away from the adder
	pasr_edge_sync #(
		.RST_VAL (1'h0)
	) u_ck_sync (
		.i_mclk  (i_mclk),
		.i_rst_n (rst_n),
		.i_pin   (i_synth_input_clock),
		.o_level (),
		.o_rise  (ck_rise),
		.o_fall  (ck_fall)
	);

	// bundle the bus request
	assign req.addr  = i_paddr;
	assign req.write = i_pwrite;
	assign req.wdata = i_pwdata;
	assign req.strb0 = i_pstrb[0];

	// address decode for reads and for the error response
	// unimplemented bits stay at zero from the default assignment
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		case (req.addr)
			`PASR_OFS_ACC_LOW:  rd_mux[7:0] = accum_q[7:0];
			`PASR_OFS_ACC_HIGH: rd_mux[7:0] = accum_q[15:8];
			`PASR_OFS_ACC_UP:   rd_mux[UP_W-1:0] = accum_q[ACC_W-1:16];
			`PASR_OFS_STP_LOW:  rd_mux[7:0] = step_q[7:0];
			`PASR_OFS_STP_HIGH: rd_mux[7:0] = step_q[15:8];
			`PASR_OFS_STP_UP:   rd_mux[UP_W-1:0] = step_q[ACC_W-1:16];
			`PASR_OFS_CTRL: begin
				rd_mux[`PASR_CTRL_EN_BIT]  = enable_q;
				rd_mux[`PASR_CTRL_PND_BIT] = pending_q;
			end
			default: mapped = 1'b0;
		endcase
	end

	// zero wait states: answer in the first access cycle
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~mapped;
	assign wr_ok     = i_psel & i_penable & req.write & req.strb0 & mapped;

	// one strobe per register keeps the write decode in one place
	assign wr_acc_low  = wr_ok && req.addr == `PASR_OFS_ACC_LOW;
	assign wr_acc_high = wr_ok && req.addr == `PASR_OFS_ACC_HIGH;
	assign wr_acc_up   = wr_ok && req.addr == `PASR_OFS_ACC_UP;
	assign wr_stp_low  = wr_ok && req.addr == `PASR_OFS_STP_LOW;
	assign wr_stp_high = wr_ok && req.addr == `PASR_OFS_STP_HIGH;
	assign wr_stp_up   = wr_ok && req.addr == `PASR_OFS_STP_UP;
	assign wr_ctrl     = wr_ok && req.addr == `PASR_OFS_CTRL;

	// read data captured in the setup cycle; a live accumulator byte may
	// move between two byte reads, software has to cope with that
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 32'h00000000;
		end else if (i_psel && !i_penable && !req.write) begin
			prdata_q <= rd_mux;
		end
	end
	assign o_prdata = prdata_q;

	// control register: enable bit
	// clearing it freezes the accumulator and makes step writes load one edge after the write
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= 1'b0;
		end else if (wr_ctrl) begin
			enable_q <= req.wdata[`PASR_CTRL_EN_BIT];
		end
	end

	// step registers as software sees them
	// the adder never reads these directly, only through the shadow
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			step_q <= ACC_W'(`PASR_RST_STEP);
		end else if (wr_ok) begin
			case (req.addr)
				`PASR_OFS_STP_LOW:  step_q[7:0] <= req.wdata[7:0];
				`PASR_OFS_STP_HIGH: step_q[15:8] <= req.wdata[7:0];
				`PASR_OFS_STP_UP:   step_q[ACC_W-1:16] <= req.wdata[UP_W-1:0];
				default: step_q <= step_q;
			endcase
		end
	end

	// low-byte write arms the load; the arm wins over a same-cycle fall
	// so the load always sees the freshly written byte
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			pending_q <= 1'b0;
		end else if (wr_stp_low && enable_q) begin
			pending_q <= 1'b1;
		end else if (shadow_load) begin
			pending_q <= 1'b0;
		end
	end

	// any step write while disabled loads the shadow on the next cycle
	// the one-cycle delay lets the written byte settle in step_q first
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			step_wr_seen_q <= 1'b0;
		end else begin
			step_wr_seen_q <= wr_stp_low | wr_stp_high | wr_stp_up;
		end
	end

	// a pending load left over when the oscillator stops is done at once
	assign shadow_load = (step_wr_seen_q & ~enable_q) |
		(pending_q & (ck_fall | ~enable_q));

	// shadow copy used by the adder
	// changing only on a load keeps a half-written step out of the sum
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			shadow_q <= ACC_W'(`PASR_RST_STEP);
		end else if (shadow_load) begin
			shadow_q <= step_q;
		end
	end

	// the carry bit is kept apart so that a wrap can be flagged
	assign sum_w = {1'b0, accum_q} + {1'b0, shadow_q};

	// a software write in the same cycle wins and the rise is dropped
	assign accum_add = ck_rise & enable_q & ~(wr_acc_low | wr_acc_high | wr_acc_up);

	// accumulator; a software write wins, running writes are undefined
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			accum_q <= ACC_W'(`PASR_RST_ACC);
		end else if (wr_acc_low) begin
			accum_q[7:0] <= req.wdata[7:0];
		end else if (wr_acc_high) begin
			accum_q[15:8] <= req.wdata[7:0];
		end else if (wr_acc_up) begin
			accum_q[ACC_W-1:16] <= req.wdata[UP_W-1:0];
		end else if (accum_add) begin
			accum_q <= sum_w[ACC_W-1:0];
		end
	end

	// carry out of the adder marks an overflow, one mclk pulse
	// it is taken only when the sum is really stored
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_q <= 1'b0;
		end else begin
			overflow_q <= accum_add & sum_w[ACC_W];
		end
	end

	// outputs come straight from flops
	assign o_phase_accum  = accum_q;
	assign o_overflow     = overflow_q;
	assign o_synth_enable = enable_q;
endmodule

// two-flop synchroniser for one pin, with edge strobes behind it
module pasr_edge_sync #(
	parameter bit RST_VAL = 1'h0
) (
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic sync1_q;
	logic sync2_q;
	logic prev_q;

	// only the second flop reads the first, so a metastable first stage
	// has a whole mclk period to settle before any logic looks at it
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= RST_VAL;
			sync2_q <= RST_VAL;
			prev_q  <= RST_VAL;
		end else begin
			sync1_q <= i_pin;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// reset value must match the pin's idle level, or a false edge
	// follows reset; a rise or fall strobe lasts exactly one mclk
	assign o_level = sync2_q;
	assign o_rise  = sync2_q & ~prev_q;
	assign o_fall  = ~sync2_q & prev_q;
endmodule
`default_nettype wire

/* bench/pasr_properties.sv */
// port assertions for the phase register slice
`timescale 1ns/1ps
`default_nettype none
module pasr_properties #(
	parameter int ACC_W = 20
) (
	input wire logic             i_mclk,
	input wire logic             i_nrst,
	input wire logic             i_psel,
	input wire logic             i_penable,
	input wire logic             i_pwrite,
	input wire logic [7:0]       i_paddr,
	input wire logic [31:0]      i_pwdata,
	input wire logic [3:0]       i_pstrb,
	input wire logic             i_synth_input_clock,
	input wire logic [31:0]      o_prdata,
	input wire logic             o_pslverr,
	input wire logic [ACC_W-1:0] o_phase_accum,
	input wire logic             o_overflow,
	input wire logic             o_synth_enable
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	// access-phase strobes; read data is valid only here
	wire logic rd = i_psel && i_penable && !i_pwrite;
	wire logic wr = i_psel && i_penable && i_pwrite;
	// read side: byte-wide registers, unimplemented nibbles
	a_byte_read: assert property (rd && !o_pslverr |-> o_prdata[31:8] == 24'h0)
		else $error("wide read");
	a_nibble_zero: assert property (rd && i_paddr inside {8'h08, 8'h14}
		|-> o_prdata[7:4] == 4'h0) else $error("upper nibble set");
	a_low_byte: assert property (rd && i_paddr == 8'h00
		|-> o_prdata[7:0] == $past(o_phase_accum[7:0])) else $error("low byte");
	// accumulator moves only on bus writes and detected input clock rises
	a_idle_hold: assert property (!o_synth_enable && !wr |=> $stable(o_phase_accum))
		else $error("moved while off");
	// a move not caused by a bus write follows a pin rise seen while on;
	// a zero step is legal, so a rise alone need not move the value
	a_rise_adds: assert property ($changed(o_phase_accum) && !$past(wr)
		|-> $past(o_synth_enable) && $past(i_synth_input_clock, 3)
		&& !$past(i_synth_input_clock, 4)) else $error("move without rise");
	// carry out means the sum wrapped
	a_wrap: assert property (o_overflow |-> o_phase_accum < $past(o_phase_accum))
		else $error("bad carry");
	a_pulse: assert property (o_overflow |=> !o_overflow) else $error("long carry");
	a_enable_bit: assert property (wr && i_pstrb[0] && i_paddr == 8'h18
		|=> o_synth_enable == $past(i_pwdata[0])) else $error("enable lost");
endmodule
bind pasr_top pasr_properties #(.ACC_W(ACC_W)) u_props (.*);
`default_nettype wire

/* bench/pasr_top_tb.sv */
// self-checking bench for the phase register slice
`timescale 1ns/1ps
`default_nettype none
module pasr_top_tb;
	logic        clk = 1'h0, nrst = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, nclk = 1'h0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic [19:0] acc;
	logic        rdy, err, ovf, en;
	int          fail_count = 0, num_checks = 0, cyc = 0;
	pasr_top uut (.i_mclk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .i_pstrb(4'hF),
		.i_synth_input_clock(nclk), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err),
		.o_phase_accum(acc), .o_overflow(ovf), .o_synth_enable(en));
	// system clock, 100 ns period
	initial forever #50 clk = ~clk;
	// cut a hang short; the whole run needs about 140 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED reg %h expected %h seen %h", a, e, s);
		end
	endtask
	// one transfer; a read compares its data with d, then an idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwr  <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		if (!w)
			chk(a, rdat, d);
		chk(a, 32'(err), 32'(a > 8'h18));
		psel <= 1'h0;
		pen  <= 1'h0;
		@(posedge clk);
	endtask
	// input clock periods, four system clocks per level
	task automatic pulse(input int n);
		repeat (2 * n) begin
			nclk <= ~nclk;
			repeat (4) @(posedge clk);
		end
	endtask
	// sequences of bus calls; accumulator is only read while stopped
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 7; i++)
			apb(1'h0, 8'(4 * i), 32'(i == 3));
		apb(1'h0, 8'h1C, 32'h0);
		apb(1'h1, 8'h08, 32'hFF);
		apb(1'h1, 8'h04, 32'hFF);
		apb(1'h1, 8'h00, 32'h80);
		apb(1'h0, 8'h08, 32'h0F);
		apb(1'h1, 8'h0C, 32'h00);
		apb(1'h1, 8'h10, 32'h01);
		apb(1'h1, 8'h14, 32'hF0);
		apb(1'h0, 8'h14, 32'h00);
		apb(1'h0, 8'h10, 32'h01);
		apb(1'h1, 8'h18, 32'h01);
		pulse(1);
		apb(1'h1, 8'h18, 32'h00);
		apb(1'h0, 8'h00, 32'h80);
		apb(1'h0, 8'h04, 32'h00);
		apb(1'h0, 8'h08, 32'h00);
		apb(1'h1, 8'h18, 32'h01);
		apb(1'h1, 8'h10, 32'h00);
		apb(1'h1, 8'h0C, 32'h40);
		apb(1'h0, 8'h18, 32'h03);
		pulse(2);
		apb(1'h0, 8'h18, 32'h01);
		apb(1'h1, 8'h18, 32'h00);
		apb(1'h0, 8'h00, 32'hC0);
		apb(1'h0, 8'h04, 32'h01);
		pulse(2);
		apb(1'h0, 8'h00, 32'hC0);
		give_verdict();
	end
endmodule
`default_nettype wire
